// *** logic/nsl_pkg.sv ***
package nsl_pkg;

    localparam int POS_W = 32;
    localparam int ERR_W = 33;
    localparam int SPD_W = 16;
    localparam int NW_W = 31;
    localparam int IL_W = 14;
    localparam int EV_W = 3;
    localparam int CH_N = 2;

    // near width range; the reset value is the widest setting
    localparam logic [31:0] NEAR_WIDTH_MIN = 32'h00000001;
    localparam logic [31:0] NEAR_WIDTH_MAX = 32'h40000000;
    localparam logic [NW_W-1:0] NEAR_WIDTH_RST = 31'h40000000;
    // internal speed limit, 1 rpm per step
    localparam logic [31:0] INT_LIMIT_MAX = 32'h00002710;
    localparam logic [IL_W-1:0] INT_LIMIT_RST = 14'h2710;
    // motor figures are loaded by software; plain defaults only
    localparam logic [SPD_W-1:0] MOTOR_MAX_RST = 16'h1770;
    localparam logic [SPD_W-1:0] OVERSPEED_RST = 16'h1b58;
    localparam logic [SPD_W-1:0] LIMIT_RST = 16'h0000;

    localparam logic [5:0] ADDR_CTRL = 6'h00;
    localparam logic [5:0] ADDR_NEAR_WIDTH = 6'h04;
    localparam logic [5:0] ADDR_INT_LIMIT = 6'h08;
    localparam logic [5:0] ADDR_MOTOR_MAX = 6'h0c;
    localparam logic [5:0] ADDR_OVERSPEED = 6'h10;
    localparam logic [5:0] ADDR_EXT_LIMIT = 6'h14;
    localparam logic [5:0] ADDR_STATUS = 6'h18;
    localparam logic [5:0] ADDR_EVENT = 6'h1c;
    localparam logic [5:0] ADDR_MASK = 6'h20;
    localparam logic [5:0] ADDR_EFF_LIMIT = 6'h24;

    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_CEIL_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;
    localparam int CTRL_APPLY_BIT = 3;

    localparam int ST_NEAR_BIT = 0;
    localparam int ST_LIMIT_BIT = 1;
    localparam int ST_SHUT_BIT = 2;
    localparam int ST_CHA_BIT = 3;
    localparam int ST_CHB_BIT = 4;
    localparam int ST_SRC_BIT = 5;
    localparam int ST_CEIL_BIT = 6;

    localparam int EV_NEAR = 0;
    localparam int EV_LIMIT = 1;
    localparam int EV_SHUT = 2;

    typedef enum logic {SRC_INTERNAL = 1'b0, SRC_EXTERNAL = 1'b1} nsl_src_type;
    typedef enum logic {CEIL_MOTOR_MAX = 1'b0, CEIL_OVERSPEED = 1'b1} nsl_ceil_type;
    typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} nsl_bus_type;

    typedef struct packed {
        logic [IL_W-1:0] int_limit;
        logic [SPD_W-1:0] motor_max;
        logic [SPD_W-1:0] overspeed;
        logic [SPD_W-1:0] ext_limit;
        nsl_src_type src;
        nsl_ceil_type ceil;
    } nsl_limit_cfg_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } nsl_sync_type;

    typedef struct packed {
        logic [SPD_W-1:0] limit;
    } nsl_lim_type;

    typedef struct packed {
        logic [NW_W-1:0] near_width;
        logic [IL_W-1:0] int_limit;
        logic [SPD_W-1:0] motor_max;
        logic [SPD_W-1:0] overspeed;
        logic [SPD_W-1:0] ext_limit;
        nsl_src_type src_pend;
        nsl_ceil_type ceil_pend;
        nsl_src_type src_act;
        nsl_ceil_type ceil_act;
        logic apply;
        logic [ERR_W-1:0] err_abs;
        logic [SPD_W-1:0] spd_abs;
        logic near;
        logic lim_act;
        logic shut_prev;
        logic [EV_W-1:0] events;
        logic [EV_W-1:0] mask;
        nsl_bus_type bus;
        logic [31:0] rdata;
    } nsl_state_type;

    localparam nsl_state_type STATE_RST = '{
        near_width: NEAR_WIDTH_RST,
        int_limit: INT_LIMIT_RST,
        motor_max: MOTOR_MAX_RST,
        overspeed: OVERSPEED_RST,
        src_pend: SRC_INTERNAL,
        ceil_pend: CEIL_MOTOR_MAX,
        src_act: SRC_INTERNAL,
        ceil_act: CEIL_MOTOR_MAX,
        bus: BUS_IDLE,
        default: '0
    };

    function automatic logic [31:0] merge_be(
        input logic [31:0] old_val,
        input logic [31:0] wr_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wr_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// *** logic/nsl_sync.sv ***
`timescale 1ns/100ps
module nsl_sync (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_pin,
    output logic o_level
);
    nsl_pkg::nsl_sync_type r_reg;
    nsl_pkg::nsl_sync_type r_next;

    // a change counts only once the second and third stage agree
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = i_pin;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        if (r_reg.s2 == r_reg.s3)
        begin
            r_next.level = r_reg.s3;
        end
    end

    // reset to off: a channel reads as a shut-off request until proven on
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign o_level = r_reg.level;
endmodule

// *** logic/nsl_limit_calc.sv ***
`timescale 1ns/100ps
module nsl_limit_calc (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire nsl_pkg::nsl_limit_cfg_type i_cfg,
    output logic [nsl_pkg::SPD_W-1:0] o_limit
);
    nsl_pkg::nsl_lim_type r_reg;
    nsl_pkg::nsl_lim_type r_next;
    logic [nsl_pkg::SPD_W-1:0] ceiling;
    logic [nsl_pkg::SPD_W-1:0] int_wide;
    logic [nsl_pkg::SPD_W-1:0] internal;

    always_comb
    begin
        r_next = r_reg;
        ceiling = (i_cfg.ceil == nsl_pkg::CEIL_OVERSPEED) ? i_cfg.overspeed
                                                         : i_cfg.motor_max; // see R7
        int_wide = {{(nsl_pkg::SPD_W-nsl_pkg::IL_W){1'b0}}, i_cfg.int_limit};
        internal = (int_wide > ceiling) ? ceiling : int_wide; // see R8
        r_next.limit = (i_cfg.src == nsl_pkg::SRC_EXTERNAL) ? i_cfg.ext_limit
                                                            : internal; // see R5
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            r_reg <= '{limit: nsl_pkg::LIMIT_RST};
        else
            r_reg <= r_next;
    end

    assign o_limit = r_reg.limit;

    property p_ceiling_sub;
        @(posedge i_clock) disable iff (i_sys_rst)
        (!i_sys_rst && i_cfg.src == nsl_pkg::SRC_INTERNAL && int_wide > ceiling)
            |=> o_limit == $past(ceiling);
    endproperty
    a_ceiling_sub: assert property (p_ceiling_sub) else $error("limit not clipped to ceiling"); // see R8
endmodule

// *** logic/nsl_top.sv ***
// Contract
// R1: near output high while position error is below the near width.
// R2: near width accepts 1 to 1073741824, resets to maximum, applies at once.
// R3: host should set near width above the completed width.
// R4: limit-active output high while limiting applies and speed reached the limit.
// R5: source select: 0 internal setting, 1 external value; applies on restart.
// R6: internal speed limit accepts 0 to 10000 rpm, resets to 10000, applies at once.
// R7: ceiling select: 0 motor maximum, 1 overspeed speed; applies on restart.
// R8: internal setting above the ceiling is replaced by the ceiling.
// R9: each shut-off channel alone blocks the power stage run signal.
// R10: shut-off state whenever either safety channel is off.
// R11: near and limit outputs recomputed each cycle from registered values.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module nsl_top (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic signed [nsl_pkg::POS_W-1:0] i_pos_ref,
    input wire logic signed [nsl_pkg::POS_W-1:0] i_pos_fb,
    input wire logic signed [nsl_pkg::SPD_W-1:0] i_motor_speed,
    input wire logic i_run_request,
    input wire logic i_shutoff_a_on,
    input wire logic i_shutoff_b_on,
    output logic o_near,
    output logic o_speed_limit_active,
    output logic [nsl_pkg::SPD_W-1:0] o_speed_limit,
    output logic o_run_enable,
    output logic o_shutoff_active,
    output logic o_irq
);
    nsl_pkg::nsl_state_type r;
    nsl_pkg::nsl_state_type n;
    nsl_pkg::nsl_limit_cfg_type cfg;
    logic [nsl_pkg::CH_N-1:0] chan_raw;
    logic [nsl_pkg::CH_N-1:0] chan_on;
    logic [nsl_pkg::SPD_W-1:0] limit_w;
    logic shut;
    logic req;
    logic signed [nsl_pkg::ERR_W-1:0] diff;
    logic [nsl_pkg::ERR_W-1:0] err_now;
    logic [nsl_pkg::SPD_W-1:0] spd_now;
    logic [31:0] rd_mux;
    logic [31:0] wv;
    logic [nsl_pkg::EV_W-1:0] ev_set;
    logic [nsl_pkg::EV_W-1:0] clr;
    logic wr_ack;
    logic rd_ack;
    logic restart_wr;

    assign chan_raw = {i_shutoff_b_on, i_shutoff_a_on};

    // both channels pass the same filter, so neither can lag the other by design
    genvar gi;
    generate
        for (gi = 0; gi < nsl_pkg::CH_N; gi++)
        begin : g_chan
            nsl_sync u_sync (
                .i_clock(i_clock),
                .i_sys_rst(i_sys_rst),
                .i_pin(chan_raw[gi]),
                .o_level(chan_on[gi])
            );
        end
    endgenerate

    assign shut = ~(&chan_on); // see R10

    // gating stays combinational so a cut needs no further clock edge
    assign o_run_enable = i_run_request & chan_on[0] & chan_on[1]; // see R9
    assign o_shutoff_active = shut;

    assign cfg.int_limit = r.int_limit;
    assign cfg.motor_max = r.motor_max;
    assign cfg.overspeed = r.overspeed;
    assign cfg.ext_limit = r.ext_limit;
    assign cfg.src = r.src_act;
    assign cfg.ceil = r.ceil_act;

    nsl_limit_calc u_limit (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_cfg(cfg),
        .o_limit(limit_w)
    );

    assign req = i_avs_read | i_avs_write;
    assign wr_ack = i_avs_write && (r.bus == nsl_pkg::BUS_ACK);
    assign rd_ack = i_avs_read && (r.bus == nsl_pkg::BUS_ACK);
    assign restart_wr = wr_ack && (i_avs_address == nsl_pkg::ADDR_CTRL)
        && i_avs_byteenable[0] && i_avs_writedata[nsl_pkg::CTRL_RESTART_BIT];

    always_comb
    begin
        n = r;
        clr = '0;
        ev_set = '0;
        rd_mux = '0;
        wv = '0;
        diff = $signed({i_pos_ref[nsl_pkg::POS_W-1], i_pos_ref})
             - $signed({i_pos_fb[nsl_pkg::POS_W-1], i_pos_fb});
        err_now = diff[nsl_pkg::ERR_W-1] ? -diff : diff;
        spd_now = i_motor_speed[nsl_pkg::SPD_W-1] ? -i_motor_speed : i_motor_speed;

        // one stage of registers ahead of the compares keeps timing short
        n.err_abs = err_now; // see R11
        n.spd_abs = spd_now; // see R11
        n.near = r.err_abs < {2'b00, r.near_width}; // see R1
        n.lim_act = r.apply && (r.spd_abs >= limit_w); // see R4
        n.shut_prev = shut;

        ev_set[nsl_pkg::EV_NEAR] = n.near & ~r.near;
        ev_set[nsl_pkg::EV_LIMIT] = n.lim_act & ~r.lim_act;
        ev_set[nsl_pkg::EV_SHUT] = shut & ~r.shut_prev;

        case (i_avs_address)
            nsl_pkg::ADDR_CTRL:
            begin
                rd_mux[nsl_pkg::CTRL_SRC_BIT] = r.src_pend;
                rd_mux[nsl_pkg::CTRL_CEIL_BIT] = r.ceil_pend;
                rd_mux[nsl_pkg::CTRL_APPLY_BIT] = r.apply;
            end
            nsl_pkg::ADDR_NEAR_WIDTH:
                rd_mux[nsl_pkg::NW_W-1:0] = r.near_width;
            nsl_pkg::ADDR_INT_LIMIT:
                rd_mux[nsl_pkg::IL_W-1:0] = r.int_limit;
            nsl_pkg::ADDR_MOTOR_MAX:
                rd_mux[nsl_pkg::SPD_W-1:0] = r.motor_max;
            nsl_pkg::ADDR_OVERSPEED:
                rd_mux[nsl_pkg::SPD_W-1:0] = r.overspeed;
            nsl_pkg::ADDR_EXT_LIMIT:
                rd_mux[nsl_pkg::SPD_W-1:0] = r.ext_limit;
            nsl_pkg::ADDR_STATUS:
            begin
                rd_mux[nsl_pkg::ST_NEAR_BIT] = r.near;
                rd_mux[nsl_pkg::ST_LIMIT_BIT] = r.lim_act;
                rd_mux[nsl_pkg::ST_SHUT_BIT] = shut;
                rd_mux[nsl_pkg::ST_CHA_BIT] = chan_on[0];
                rd_mux[nsl_pkg::ST_CHB_BIT] = chan_on[1];
                rd_mux[nsl_pkg::ST_SRC_BIT] = r.src_act;
                rd_mux[nsl_pkg::ST_CEIL_BIT] = r.ceil_act;
            end
            nsl_pkg::ADDR_EVENT:
                rd_mux[nsl_pkg::EV_W-1:0] = r.events;
            nsl_pkg::ADDR_MASK:
                rd_mux[nsl_pkg::EV_W-1:0] = r.mask;
            nsl_pkg::ADDR_EFF_LIMIT:
                rd_mux[nsl_pkg::SPD_W-1:0] = limit_w;
            default:
                rd_mux = '0;
        endcase

        wv = nsl_pkg::merge_be(rd_mux, i_avs_writedata, i_avs_byteenable);

        case (r.bus)
            nsl_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    n.rdata = rd_mux;
                    n.bus = nsl_pkg::BUS_ACK;
                end
            end
            nsl_pkg::BUS_ACK:
            begin
                n.bus = nsl_pkg::BUS_IDLE;
                // clear only what the read reported, so an event seen while the
                // read is pending is kept for the next read
                if (rd_ack && i_avs_address == nsl_pkg::ADDR_EVENT)
                begin
                    clr = r.rdata[nsl_pkg::EV_W-1:0];
                end
                if (wr_ack)
                begin
                    case (i_avs_address)
                        nsl_pkg::ADDR_CTRL:
                        begin
                            n.src_pend = nsl_pkg::nsl_src_type'(wv[nsl_pkg::CTRL_SRC_BIT]);
                            n.ceil_pend = nsl_pkg::nsl_ceil_type'(wv[nsl_pkg::CTRL_CEIL_BIT]);
                            n.apply = wv[nsl_pkg::CTRL_APPLY_BIT];
                            // selects only move on a restart, as a power cycle would
                            if (restart_wr)
                            begin
                                n.src_act = n.src_pend; // see R5
                                n.ceil_act = n.ceil_pend; // see R7
                            end
                        end
                        nsl_pkg::ADDR_NEAR_WIDTH:
                        begin
                            // out of range writes are dropped, old width kept
                            if (wv >= nsl_pkg::NEAR_WIDTH_MIN && wv <= nsl_pkg::NEAR_WIDTH_MAX)
                            begin
                                n.near_width = wv[nsl_pkg::NW_W-1:0]; // see R2
                            end
                        end
                        nsl_pkg::ADDR_INT_LIMIT:
                        begin
                            if (wv <= nsl_pkg::INT_LIMIT_MAX)
                            begin
                                n.int_limit = wv[nsl_pkg::IL_W-1:0]; // see R6
                            end
                        end
                        nsl_pkg::ADDR_MOTOR_MAX:
                            n.motor_max = wv[nsl_pkg::SPD_W-1:0];
                        nsl_pkg::ADDR_OVERSPEED:
                            n.overspeed = wv[nsl_pkg::SPD_W-1:0];
                        nsl_pkg::ADDR_EXT_LIMIT:
                            n.ext_limit = wv[nsl_pkg::SPD_W-1:0];
                        nsl_pkg::ADDR_MASK:
                            n.mask = wv[nsl_pkg::EV_W-1:0];
                        default:
                        begin
                        end
                    endcase
                end
            end
            default:
                n.bus = nsl_pkg::BUS_IDLE;
        endcase

        // a new event wins over a clearing read in the same cycle
        n.events = (r.events & ~clr) | ev_set;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            r <= nsl_pkg::STATE_RST;
        else
            r <= n;
    end

    assign o_avs_waitrequest = req && (r.bus == nsl_pkg::BUS_IDLE);
    assign o_avs_readdata = r.rdata;
    assign o_near = r.near;
    assign o_speed_limit_active = r.lim_act;
    assign o_speed_limit = limit_w;
    assign o_irq = |(r.events & r.mask);

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    property p_near_path;
        (!$past(i_sys_rst) && !$past(i_sys_rst, 2))
            |-> o_near == ($past(err_now, 2) < {2'b00, $past(r.near_width)});
    endproperty
    a_near_path: assert property (p_near_path) else $error("near output mismatch"); // see R1

    property p_width_range;
        {1'b0, r.near_width} >= nsl_pkg::NEAR_WIDTH_MIN
            && {1'b0, r.near_width} <= nsl_pkg::NEAR_WIDTH_MAX;
    endproperty
    a_width_range: assert property (p_width_range) else $error("near width out of range"); // see R2

    property p_width_now;
        (wr_ack && i_avs_address == nsl_pkg::ADDR_NEAR_WIDTH && i_avs_byteenable == 4'hf
            && i_avs_writedata >= nsl_pkg::NEAR_WIDTH_MIN
            && i_avs_writedata <= nsl_pkg::NEAR_WIDTH_MAX)
            |=> r.near_width == $past(i_avs_writedata[nsl_pkg::NW_W-1:0]);
    endproperty
    a_width_now: assert property (p_width_now) else $error("near width not applied"); // see R2

    property p_limit_on;
        (r.apply && r.spd_abs >= limit_w) |=> o_speed_limit_active;
    endproperty
    a_limit_on: assert property (p_limit_on) else $error("limit flag missing"); // see R4

    property p_limit_off;
        !r.apply |=> !o_speed_limit_active;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("limit flag without limiting"); // see R4

    property p_src_hold;
        !restart_wr |=> $stable(r.src_act);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source moved without restart"); // see R5

    property p_ceil_hold;
        !restart_wr |=> $stable(r.ceil_act);
    endproperty
    a_ceil_hold: assert property (p_ceil_hold) else $error("ceiling moved without restart"); // see R7

    property p_int_range;
        {18'h00000, r.int_limit} <= nsl_pkg::INT_LIMIT_MAX;
    endproperty
    a_int_range: assert property (p_int_range) else $error("internal limit out of range"); // see R6

    property p_run_block;
        (!i_shutoff_a_on [*5]) or (!i_shutoff_b_on [*5]) |-> !o_run_enable;
    endproperty
    a_run_block: assert property (p_run_block) else $error("run not blocked by channel"); // see R9

    property p_shut_filter;
        (!i_shutoff_a_on [*5]) or (!i_shutoff_b_on [*5]) |-> o_shutoff_active;
    endproperty
    a_shut_filter: assert property (p_shut_filter) else $error("shut-off state not entered"); // see R10

    property p_bus_ack;
        (req && r.bus == nsl_pkg::BUS_IDLE) ##1 req |-> !o_avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("waitrequest held too long");

    c_near: cover property ($rose(o_near));
    c_limit: cover property ($rose(o_speed_limit_active));
    c_shut: cover property ($rose(o_shutoff_active));
    c_irq: cover property ($rose(o_irq));
endmodule

// *** tb/nsl_host_model.sv ***
`timescale 1ns/100ps
module nsl_host_model (
    input wire logic i_clock,
    input wire logic signed [31:0] i_ref_cmd,
    input wire logic signed [31:0] i_fb_cmd,
    input wire logic signed [15:0] i_spd_cmd,
    output logic signed [nsl_pkg::POS_W-1:0] o_pos_ref,
    output logic signed [nsl_pkg::POS_W-1:0] o_pos_fb,
    output logic signed [nsl_pkg::SPD_W-1:0] o_motor_speed
);
    // one register stage: the controller updates references only on the clock
    logic signed [31:0] ref_reg = '0;
    logic signed [31:0] fb_reg = '0;
    logic signed [15:0] spd_reg = '0;
    always @(posedge i_clock)
    begin
        ref_reg <= i_ref_cmd;
        fb_reg <= i_fb_cmd;
        spd_reg <= i_spd_cmd;
    end
    assign o_pos_ref = ref_reg;
    assign o_pos_fb = fb_reg;
    assign o_motor_speed = spd_reg;
endmodule

// *** tb/test_near_and_speed_limit_detect.sv ***
`timescale 1ns/100ps
module test_near_and_speed_limit_detect;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wait_req;
    logic signed [31:0] ref_cmd = '0;
    logic signed [31:0] fb_cmd = '0;
    logic signed [15:0] spd_cmd = '0;
    logic signed [31:0] pos_ref;
    logic signed [31:0] pos_fb;
    logic signed [15:0] spd;
    logic ch_a = 1'b1;
    logic ch_b = 1'b1;
    logic run_req = 1'b1;
    logic near, lim_act, run_en, shut, irq;
    logic [15:0] spd_lim;
    logic [31:0] rq;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    nsl_host_model host (.i_clock(clk), .i_ref_cmd(ref_cmd), .i_fb_cmd(fb_cmd),
        .i_spd_cmd(spd_cmd), .o_pos_ref(pos_ref), .o_pos_fb(pos_fb), .o_motor_speed(spd));

    nsl_top uut (.i_clock(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_pos_ref(pos_ref),
        .i_pos_fb(pos_fb), .i_motor_speed(spd), .i_run_request(run_req),
        .i_shutoff_a_on(ch_a), .i_shutoff_b_on(ch_b), .o_near(near),
        .o_speed_limit_active(lim_act), .o_speed_limit(spd_lim), .o_run_enable(run_en),
        .o_shutoff_active(shut), .o_irq(irq));

    task automatic test_done();
        $display("errors %0d of %0d compares", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge; data taken there
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0)
            chk(1'b1, 1'b0);
        rq = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic setp(input int r, input int f, input int s);
        @(posedge clk);
        ref_cmd <= r;
        fb_cmd <= f;
        spd_cmd <= s[15:0];
    endtask

    task automatic t_defaults();
        bus(0, nsl_pkg::ADDR_NEAR_WIDTH, 0);
        chk(rq, nsl_pkg::NEAR_WIDTH_MAX);
        bus(0, nsl_pkg::ADDR_INT_LIMIT, 0);
        chk(rq, nsl_pkg::INT_LIMIT_MAX);
        bus(0, nsl_pkg::ADDR_STATUS, 0);
        chk(rq[6:5], 2'b00);
        bus(0, 6'h3c, 0);
        chk(rq, 32'h0);
        hold(1);
        chk(spd_lim, nsl_pkg::MOTOR_MAX_RST);
        chk(near, 1'b1);
    endtask

    task automatic t_near();
        // width kept above any completion width the host uses
        bus(1, nsl_pkg::ADDR_NEAR_WIDTH, 32'h64);
        setp(100, 1, 0);
        hold(4);
        chk(near, 1'b1);
        setp(1, 101, 0);
        hold(2);
        chk(near, 1'b1);
        hold(1);
        chk(near, 1'b0);
        setp(0, 99, 0);
        hold(4);
        chk(near, 1'b1);
        bus(1, nsl_pkg::ADDR_NEAR_WIDTH, 32'h63);
        hold(3);
        chk(near, 1'b0);
        bus(1, nsl_pkg::ADDR_NEAR_WIDTH, 32'h0);
        bus(0, nsl_pkg::ADDR_NEAR_WIDTH, 0);
        chk(rq, 32'h63);
        bus(1, nsl_pkg::ADDR_NEAR_WIDTH, 32'h40000001);
        bus(0, nsl_pkg::ADDR_NEAR_WIDTH, 0);
        chk(rq, 32'h63);
        bus(1, nsl_pkg::ADDR_NEAR_WIDTH, 32'h1);
        setp(5, 5, 0);
        hold(4);
        chk(near, 1'b1);
    endtask

    task automatic t_limit();
        bus(1, nsl_pkg::ADDR_INT_LIMIT, 32'hbb8);
        hold(2);
        chk(spd_lim, 16'hbb8);
        bus(1, nsl_pkg::ADDR_INT_LIMIT, 32'h2711);
        bus(0, nsl_pkg::ADDR_INT_LIMIT, 0);
        chk(rq, 32'hbb8);
        bus(1, nsl_pkg::ADDR_INT_LIMIT, 32'h1f40);
        hold(2);
        chk(spd_lim, nsl_pkg::MOTOR_MAX_RST);
        bus(1, nsl_pkg::ADDR_CTRL, 32'h2);
        hold(2);
        chk(spd_lim, nsl_pkg::MOTOR_MAX_RST);
        bus(1, nsl_pkg::ADDR_CTRL, 32'h6);
        hold(2);
        chk(spd_lim, nsl_pkg::OVERSPEED_RST);
        bus(1, nsl_pkg::ADDR_EXT_LIMIT, 32'h1f4);
        bus(1, nsl_pkg::ADDR_CTRL, 32'h1);
        hold(2);
        chk(spd_lim, nsl_pkg::OVERSPEED_RST);
        bus(1, nsl_pkg::ADDR_CTRL, 32'hd);
        hold(2);
        chk(spd_lim, 16'h1f4);
        setp(0, 0, 499);
        hold(4);
        chk(lim_act, 1'b0);
        setp(0, 0, 500);
        hold(4);
        chk(lim_act, 1'b1);
        setp(0, 0, -600);
        hold(4);
        chk(lim_act, 1'b1);
        bus(1, nsl_pkg::ADDR_CTRL, 32'h1);
        hold(3);
        chk(lim_act, 1'b0);
    endtask

    task automatic t_shut();
        chk(run_en, 1'b1);
        bus(1, nsl_pkg::ADDR_MASK, 32'h4);
        bus(0, nsl_pkg::ADDR_EVENT, 0);
        hold(1);
        chk(irq, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            ch_a <= (i != 0);
            ch_b <= (i == 0);
            hold(5);
            chk(shut, 1'b1);
            chk(run_en, 1'b0);
            chk(irq, 1'b1);
            bus(0, nsl_pkg::ADDR_STATUS, 0);
            chk(rq[4:3], (i == 0) ? 2'b10 : 2'b01);
            ch_a <= 1'b1;
            ch_b <= 1'b1;
            hold(5);
            chk(shut, 1'b0);
            bus(0, nsl_pkg::ADDR_EVENT, 0);
            chk(rq[2], 1'b1);
            hold(1);
            chk(irq, 1'b0);
        end
        // masked event must stay off the interrupt line
        bus(1, nsl_pkg::ADDR_MASK, 32'h0);
        ch_a <= 1'b0;
        hold(5);
        chk(irq, 1'b0);
        chk(run_en, 1'b0);
        @(posedge clk);
        ch_a <= 1'b1;
        hold(5);
        chk(run_en, 1'b1);
        @(posedge clk);
        run_req <= 1'b0;
        hold(1);
        chk(run_en, 1'b0);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        hold(6);
        t_defaults();
        t_near();
        t_limit();
        t_shut();
        test_done();
    end
endmodule
